// ---- hdl/tmo_pkg.sv ----
// Package for the odd-slot timer control block.
// Assumes a single 125 MHz clock domain.
package tmo_pkg;
  localparam int unsigned REG_W = 16;
  // Register index of the control register and the counter (byte address = 4 x index)
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] COUNT_ADDR = 4'h4;
  // Field positions
  localparam int unsigned RUN_BIT = 15;
  localparam int unsigned IDLE_STOP_BIT = 13;
  localparam int unsigned GATE_BIT = 6;
  localparam int unsigned PRESCALE_HI = 5;
  localparam int unsigned PRESCALE_LO = 4;
  localparam int unsigned CLK_SRC_BIT = 1;
  // Implemented bits mask and reset value
  localparam logic [15:0] CTRL_MASK = 16'hA072;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Prescale division counts
  localparam logic [7:0] DIV_1 = 8'h00;
  localparam logic [7:0] DIV_8 = 8'h07;
  localparam logic [7:0] DIV_64 = 8'h3F;
  localparam logic [7:0] DIV_256 = 8'hFF;
  // Internal clock is half the oscillator: one tick every two cycles
  localparam logic [0:0] HALF_DIV_RESET = 1'b0;
endpackage

// ---- hdl/tmo_tick_if.sv ----
// Interface carrying timer ticks between the prescaler and the main block.
// Assumes the single device clock.
`timescale 1ns/1ps
`default_nettype none
interface tmo_tick_if;
  logic raw_tick;
  logic clear;
  logic [1:0] sel;
  logic out_tick;
  modport ctl (output raw_tick, output clear, output sel, input out_tick);
  modport pre (input raw_tick, input clear, input sel, output out_tick);
endinterface
`default_nettype wire

// ---- hdl/tmo_prescaler.sv ----
// Input clock prescaler: divides input ticks by 1, 8, 64 or 256.
// Assumes ticks are one-cycle pulses on the device clock.
`timescale 1ns/1ps
`default_nettype none
module tmo_prescaler (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Tick link
  tmo_tick_if.pre tk
);
  logic [7:0] count;
  logic [7:0] limit;

  always_comb begin
    case (tk.sel)
      2'b11: limit = tmo_pkg::DIV_256; // RULE4
      2'b10: limit = tmo_pkg::DIV_64;
      2'b01: limit = tmo_pkg::DIV_8;
      default: limit = tmo_pkg::DIV_1; // RULE9
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 8'h00;
    end else if (tk.clear) begin
      count <= 8'h00; // RULE7
    end else if (tk.raw_tick) begin
      count <= (count >= limit) ? 8'h00 : count + 8'h01;
    end
  end

  assign tk.out_tick = tk.raw_tick && !tk.clear && (count >= limit);

  a_prescale_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tk.clear |=> count == 8'h00) else $error("Prescale count not cleared"); // RULE7
endmodule
`default_nettype wire

// ---- hdl/tmo_timer_ctrl.sv ----
// Odd-slot 16-bit timer with its control register and counter.
// Assumes a plain register port and an asynchronous external count pin.
//
// Behaviour
// RULE1: The run bit starts the counter when 1 and halts it when 0.
// RULE2: With idle-stop set the timer is suspended while the device idles.
// RULE3: Gated accumulation works with the internal clock only and is ignored otherwise.
// RULE4: Prescale codes 11, 10 and 01 divide the input clock by 256, 64 and 8.
// RULE5: Clock source 1 counts rising edges of the external pin, 0 uses the half-rate clock.
// RULE6: With 32-bit pairing enabled this register has no effect on the timer.
// RULE7: A write to the control register while running resets the prescale counter.
// RULE8: Unimplemented control bits ignore writes and read as zero.
// RULE9: Prescale code 00 divides by one and implemented bits reset to zero.
// RULE10: The counter increments once per prescaled tick while running and gated.
`timescale 1ns/1ps
`default_nettype none
module tmo_timer_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Device state
  input wire logic device_idle_i,
  input wire logic pair_32bit_i,
  // Pins
  input wire logic external_count_clock_i,
  input wire logic gate_i,
  // Status
  output logic [15:0] count_o,
  output logic running_o
);
  logic [15:0] odd_timer_control;
  logic [15:0] count;
  logic [2:0] ext_sync;
  logic [2:0] gate_sync;
  logic ext_level;
  logic gate_level;
  logic half_div;
  logic ext_rise;
  logic int_tick;
  logic active;
  logic ctrl_wr;
  logic timer_run;
  logic idle_stop;
  logic gated_accumulate;
  logic clock_source_select;
  logic [1:0] prescale_select;

  tmo_tick_if tk ();

  tmo_prescaler u_pre (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tk(tk)
  );

  assign timer_run = odd_timer_control[tmo_pkg::RUN_BIT];
  assign idle_stop = odd_timer_control[tmo_pkg::IDLE_STOP_BIT];
  assign gated_accumulate = odd_timer_control[tmo_pkg::GATE_BIT];
  assign clock_source_select = odd_timer_control[tmo_pkg::CLK_SRC_BIT];
  assign prescale_select = odd_timer_control[tmo_pkg::PRESCALE_HI:tmo_pkg::PRESCALE_LO];
  assign ctrl_wr = wr_i && (addr_i == tmo_pkg::CTRL_ADDR);

  // Control register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      odd_timer_control <= tmo_pkg::CTRL_RESET; // RULE9
    end else if (ctrl_wr) begin
      odd_timer_control <= wdata_i & tmo_pkg::CTRL_MASK; // RULE8
    end
  end

  // Pin synchronisers, three stages each
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 3'b000;
      gate_sync <= 3'b000;
      ext_level <= 1'b0;
      gate_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_count_clock_i};
      gate_sync <= {gate_sync[1:0], gate_i};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
      if (gate_sync[1] == gate_sync[2]) begin
        gate_level <= gate_sync[2];
      end
    end
  end

  // Edge detect on the filtered external level
  logic ext_prev;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end
  assign ext_rise = ext_level && !ext_prev; // RULE5

  // Half-rate internal clock enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_div <= tmo_pkg::HALF_DIV_RESET;
    end else begin
      half_div <= ~half_div;
    end
  end
  assign int_tick = half_div; // RULE5

  // Run qualification
  always_comb begin
    active = timer_run && !(idle_stop && device_idle_i); // RULE1 RULE2
    if (pair_32bit_i) begin
      active = 1'b0; // RULE6
    end
    if (!clock_source_select && gated_accumulate && !gate_level) begin
      active = 1'b0; // RULE3
    end
  end

  assign tk.sel = prescale_select;
  assign tk.raw_tick = active && (clock_source_select ? ext_rise : int_tick);
  assign tk.clear = ctrl_wr && timer_run; // RULE7

  // Counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= tmo_pkg::COUNT_RESET;
    end else if (wr_i && addr_i == tmo_pkg::COUNT_ADDR) begin
      count <= wdata_i;
    end else if (tk.out_tick) begin
      count <= count + 16'h0001; // RULE10
    end
  end

  // Read port, data one cycle later
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        tmo_pkg::CTRL_ADDR: rdata_o <= odd_timer_control & tmo_pkg::CTRL_MASK; // RULE8
        tmo_pkg::COUNT_ADDR: rdata_o <= count;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  assign count_o = count;
  assign running_o = active;

  a_run_stops_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!timer_run && !wr_i) |=> $stable(count)) else $error("Count moved while stopped"); // RULE1
  a_idle_suspends: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (idle_stop && device_idle_i && !wr_i) |=> $stable(count)) else $error("Count moved in idle"); // RULE2
  a_gate_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!clock_source_select && gated_accumulate && !gate_level) |-> !tk.raw_tick)
    else $error("Gate ignored"); // RULE3
  a_pair_disables: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pair_32bit_i |-> !tk.raw_tick) else $error("Pairing ignored"); // RULE6
  a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (odd_timer_control & ~tmo_pkg::CTRL_MASK) == 16'h0000) else $error("Reserved bit set"); // RULE8
  a_div1_passes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (prescale_select == 2'b00 && tk.raw_tick && !tk.clear) |-> tk.out_tick)
    else $error("Divide by one lost tick"); // RULE9
  a_tick_counts: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tk.out_tick && !wr_i) |=> count == $past(count) + 16'h0001)
    else $error("Tick not counted"); // RULE10
  a_internal_half: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!clock_source_select && tk.raw_tick) |=> !tk.raw_tick) else $error("Internal rate too high"); // RULE5
  a_div8_spacing: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (prescale_select == 2'b01 && !clock_source_select && tk.out_tick && !wr_i)
    |=> !tk.out_tick [*8]) else $error("Divide by eight too fast"); // RULE4
endmodule
`default_nettype wire

// ---- verif/tmo_pin_model.sv ----
// Pin model: external count clock and gate pin of the odd-slot timer.
// Assumes the bench clock; the pin clock stands low unless enabled.
`timescale 1ns/1ps
`default_nettype none
module tmo_pin_model #(parameter int HALF = 4) (
  // Clock
  input wire logic ref_clk_i,
  // Control from bench
  input wire logic run_i,
  input wire logic gate_lvl_i,
  // Pins
  output logic ext_clk_o,
  output logic gate_o
);
  int cnt = 0;
  initial ext_clk_o = 1'b0;
  // Square wave, each level held HALF cycles
  always @(posedge ref_clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      ext_clk_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clk_o <= !ext_clk_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign gate_o = gate_lvl_i;
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench for the odd-slot timer control block.
// Assumes the pin model drives the count clock and gate pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, wr, rd, idle, pair, ext_en, gate_lvl, ext_clk, gate, running;
  logic pend = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, count;
  logic [15:0] q[$];
  logic [31:0] seed = 32'hc43f;
  int err_count = 0;
  int n_tests = 0;
  tmo_timer_ctrl tmo_timer_ctrl_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .device_idle_i(idle),
    .pair_32bit_i(pair), .external_count_clock_i(ext_clk), .gate_i(gate),
    .count_o(count), .running_o(running));
  tmo_pin_model tmo_pin_model_inst (.ref_clk_i(clk), .run_i(ext_en), .gate_lvl_i(gate_lvl),
    .ext_clk_o(ext_clk), .gate_o(gate));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Read data stands in the cycle after the strobe
  always @(negedge clk) begin
    if (pend) check("rdata", rdata, q.pop_front());
    pend = rd;
  end
  // Counter advance over a fixed span
  task automatic meas(input string nm, input logic [15:0] c, input int cyc,
                      input logic [15:0] e);
    logic [15:0] c1;
    wr_reg(tmo_pkg::CTRL_ADDR, c);
    repeat (600) @(posedge clk);
    @(negedge clk);
    c1 = count;
    repeat (cyc) @(negedge clk);
    check(nm, count - c1, e);
    check({nm, "_running"}, {15'h0000, running}, {15'h0000, e != 16'h0000});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 30000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    idle = 1'b0;
    pair = 1'b0;
    ext_en = 1'b0;
    gate_lvl = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(tmo_pkg::CTRL_ADDR, 16'h0000);
    rd_reg(tmo_pkg::COUNT_ADDR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr_reg(tmo_pkg::CTRL_ADDR, seed[15:0] & 16'h7fff);
      rd_reg(tmo_pkg::CTRL_ADDR, seed[15:0] & 16'h7fff & tmo_pkg::CTRL_MASK);
      rd_reg({1'b1, seed[18:16]}, 16'h0000);
    end
    for (int k = 0; k < 4; k++) begin
      meas("prescale", 16'h8000 | 16'(k << 4), (k == 3) ? 2048 : (8 << (3 * k)),
           16'h0004);
    end
    meas("stopped", 16'h0000, 64, 16'h0000);
    idle <= 1'b1;
    meas("idle_stop", 16'ha000, 64, 16'h0000);
    meas("idle_run", 16'h8000, 64, 16'h0020);
    idle <= 1'b0;
    pair <= 1'b1;
    meas("paired", 16'h8000, 64, 16'h0000);
    pair <= 1'b0;
    meas("gate_low", 16'h8040, 64, 16'h0000);
    gate_lvl <= 1'b1;
    meas("gate_high", 16'h8040, 64, 16'h0020);
    gate_lvl <= 1'b0;
    ext_en <= 1'b1;
    meas("ext_clock", 16'h8042, 64, 16'h0008);
    ext_en <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
